// *** logic/icd_class_decode.sv ***
// Instruction class decode: byte selection, latches and operand register
module icd_class_decode (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Microsequencer and control word
   input wire logic decode_cycle,
   input wire logic [icd_pkg::CW_W-1:0] control_word,
   input wire logic table_enable,
   input wire logic compat_mode,
   input wire logic intr_pending,
   input wire logic set_backup_mask,
   // Prefetch buffer and PC
   input wire logic [31:0] prefetch_buffer,
   input wire logic fetched_byte_valid,
   input wire logic [1:0] pc_low,
   input wire logic [31:0] pc_incremented,
   // Class lookup and branch condition
   input wire logic [1:0] class_size,
   input wire logic [1:0] class_cc,
   input wire logic is_cond_branch,
   input wire logic cond_met,
   // Dispatch tables
   input wire logic [7:0] opcode_table_data,
   input wire logic [7:0] spec_table_data,
   // Outputs
   output logic dispatch_valid,
   output logic [7:0] dispatch_addr,
   output logic opcode_table_en,
   output logic spec_table_en,
   output logic [7:0] opcode_reg,
   output logic [7:0] instruction_byte_bus,
   output logic byte_removed,
   output logic [1:0] byte_select,
   output logic ls_pc_write,
   output logic [31:0] ls_pc_data,
   output logic wr_pc_write,
   output logic [1:0] operand_size,
   output logic [1:0] cc_class_latch,
   output logic branch_not_taken,
   output logic legacy_first_decode_flag,
   output logic [7:0] operand_register,
   output logic [1:0] operand_reg_control,
   output logic backup_mask_valid
);
   import icd_pkg::*;

   logic byte_request, pc_hold_bit, upper_byte_select, table_select;
   logic operand_reg_load, dest_register_check;
   logic [2:0] decode_function_field;
   logic first_decode_strobe, use_spec, tables_on;
   logic [1:0] sel;
   logic [7:0] sel_byte;
   logic [1:0] next_ctl;
   logic [7:0] next_opreg;

   assign byte_request = decode_cycle & control_word[CW_BYTE_REQ];
   assign pc_hold_bit = control_word[CW_HOLD_PC];
   assign upper_byte_select = control_word[CW_UPPER_SEL];
   assign table_select = control_word[CW_TABLE_SEL];
   assign operand_reg_load = control_word[CW_OPREG_LOAD];
   assign dest_register_check = control_word[CW_DEST_CHECK];
   assign decode_function_field = control_word[CW_FUNC_HI:CW_FUNC_LO];

   // Byte selection from the prefetch buffer
   always_comb begin
      if (compat_mode) begin
         sel = {byte_select[1], upper_byte_select};
      end else begin
         sel = byte_select;
      end
      sel_byte = prefetch_buffer[8*sel +: 8];
   end

   // Strobes and table selection
   assign first_decode_strobe = decode_cycle & table_select &
      fetched_byte_valid &
      ((decode_function_field == FUNC_NATIVE_CLASS) |
       (decode_function_field == FUNC_COMPAT_CLASS));
   assign tables_on = decode_cycle & table_enable;
   assign use_spec = ~table_select | (~compat_mode & intr_pending &
      (decode_function_field == FUNC_NATIVE_CLASS));

   // Operand register control
   always_comb begin
      if (legacy_first_decode_flag && !decode_cycle) begin
         next_ctl = OPC_ASSEMBLE;
      end else if (!operand_reg_load || !decode_cycle) begin
         next_ctl = OPC_HOLD;
      end else if (dest_register_check && compat_mode) begin
         next_ctl = OPC_LOAD_CLR3;
      end else begin
         next_ctl = OPC_LOAD;
      end
      case (next_ctl)
         OPC_LOAD: next_opreg = sel_byte;
         OPC_LOAD_CLR3: next_opreg = {sel_byte[7:4], 1'b0, sel_byte[2:0]};
         OPC_ASSEMBLE: next_opreg = {operand_register[5:2],
            1'b0, operand_register[0], sel_byte[7:6]};
         default: next_opreg = operand_register;
      endcase
   end

   // Byte selection and PC update
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         byte_select <= 2'h0;
         ls_pc_write <= 1'b0;
         wr_pc_write <= 1'b0;
         ls_pc_data <= 32'h0;
         byte_removed <= 1'b0;
         instruction_byte_bus <= 8'h00;
      end else begin
         byte_removed <= decode_cycle & (byte_request | compat_mode);
         instruction_byte_bus <= sel_byte;
         ls_pc_write <= byte_request & ~compat_mode;
         wr_pc_write <= byte_request & ~compat_mode & ~pc_hold_bit;
         ls_pc_data <= pc_incremented;
         if (byte_request && !compat_mode) begin
            byte_select <= pc_incremented[1:0];
         end else if (!decode_cycle) begin
            byte_select <= pc_low;
         end
      end
   end

   // Dispatch
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         dispatch_valid <= 1'b0;
         dispatch_addr <= 8'h00;
         opcode_table_en <= 1'b0;
         spec_table_en <= 1'b0;
         opcode_reg <= 8'h00;
      end else begin
         dispatch_valid <= tables_on & fetched_byte_valid;
         opcode_table_en <= tables_on & ~use_spec;
         spec_table_en <= tables_on & use_spec;
         if (use_spec && table_select) begin
            dispatch_addr <= INTR_DISPATCH;
         end else if (use_spec) begin
            dispatch_addr <= spec_table_data;
         end else begin
            dispatch_addr <= opcode_table_data;
         end
         if (first_decode_strobe) begin
            opcode_reg <= sel_byte;
         end
      end
   end

   // Class latches and flags
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         operand_size <= LATCH_RESET;
         cc_class_latch <= LATCH_RESET;
         branch_not_taken <= 1'b0;
         legacy_first_decode_flag <= 1'b0;
         backup_mask_valid <= 1'b0;
      end else begin
         if (first_decode_strobe) begin
            operand_size <= class_size;
            cc_class_latch <= class_cc;
            branch_not_taken <= is_cond_branch & ~cond_met;
         end
         legacy_first_decode_flag <= first_decode_strobe;
         if (first_decode_strobe) begin
            backup_mask_valid <= 1'b0;
         end else if (set_backup_mask) begin
            backup_mask_valid <= 1'b1;
         end
      end
   end

   // Operand register
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         operand_register <= OPREG_RESET;
         operand_reg_control <= OPC_HOLD;
      end else begin
         operand_register <= next_opreg;
         operand_reg_control <= next_ctl;
      end
   end

   // Checks
   default clocking chk_clk @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   opcode_load_a: assert property (
      first_decode_strobe |=> opcode_reg == instruction_byte_bus)
      else $error("opcode register not loaded");
   no_valid_a: assert property (
      decode_cycle && !fetched_byte_valid |=>
      !dispatch_valid && !legacy_first_decode_flag)
      else $error("dispatch without valid byte");
   native_take_a: assert property (
      byte_request && !compat_mode |=> byte_removed)
      else $error("native byte not removed");
   pc_write_a: assert property (
      byte_request && !compat_mode |=>
      ls_pc_write && ls_pc_data == $past(pc_incremented) &&
      byte_select == $past(pc_incremented[1:0]))
      else $error("pc update missing");
   hold_pc_a: assert property (
      wr_pc_write |-> ls_pc_write)
      else $error("working pc write without pc write");
   pc_copy_a: assert property (
      byte_request && !compat_mode |=> wr_pc_write != $past(pc_hold_bit))
      else $error("working pc write wrong");
   compat_take_a: assert property (
      decode_cycle && compat_mode |=>
      byte_removed && !ls_pc_write && $stable(byte_select))
      else $error("compat byte removal wrong");
   lower_byte_a: assert property (
      decode_cycle && compat_mode && !upper_byte_select && byte_select[1] |=>
      instruction_byte_bus == $past(prefetch_buffer[23:16]))
      else $error("compat low byte wrong");
   upper_low_a: assert property (
      decode_cycle && compat_mode && upper_byte_select && !byte_select[1] |=>
      instruction_byte_bus == $past(prefetch_buffer[15:8]))
      else $error("compat byte 1 wrong");
   upper_high_a: assert property (
      decode_cycle && compat_mode && upper_byte_select && byte_select[1] |=>
      instruction_byte_bus == $past(prefetch_buffer[31:24]))
      else $error("compat byte 3 wrong");
   opc_table_a: assert property (
      decode_cycle && table_enable && table_select &&
      (compat_mode || !intr_pending) |=>
      opcode_table_en && !spec_table_en &&
      dispatch_addr == $past(opcode_table_data))
      else $error("opcode table dispatch wrong");
   intr_disp_a: assert property (
      tables_on && table_select && !compat_mode && intr_pending &&
      decode_function_field == FUNC_NATIVE_CLASS |=>
      spec_table_en && dispatch_addr == INTR_DISPATCH)
      else $error("interrupt dispatch wrong");
   tables_off_a: assert property (
      !decode_cycle || !table_enable |=>
      !opcode_table_en && !spec_table_en && !dispatch_valid)
      else $error("tables enabled outside decode");
   latch_hold_a: assert property (
      !first_decode_strobe |=>
      $stable(operand_size) && $stable(cc_class_latch))
      else $error("class latch changed without strobe");
   size_latch_a: assert property (
      first_decode_strobe |=> operand_size == $past(class_size))
      else $error("size latch wrong");
   cc_latch_a: assert property (
      first_decode_strobe |=> cc_class_latch == $past(class_cc))
      else $error("cc latch wrong");
   branch_not_taken_a: assert property (
      first_decode_strobe |=> branch_not_taken ==
      ($past(is_cond_branch) && !$past(cond_met)))
      else $error("branch flag wrong");
   branch_hold_a: assert property (
      !first_decode_strobe |=> $stable(branch_not_taken))
      else $error("branch flag changed without strobe");
   strobe_flag_a: assert property (
      first_decode_strobe |=> legacy_first_decode_flag)
      else $error("flag not set after strobe");
   hold_ctl_a: assert property (
      decode_cycle && !operand_reg_load |=>
      operand_reg_control == OPC_HOLD && $stable(operand_register))
      else $error("operand register not held");
   clr3_load_a: assert property (
      decode_cycle && operand_reg_load && dest_register_check &&
      compat_mode |=> operand_reg_control == OPC_LOAD_CLR3 &&
      operand_register == (instruction_byte_bus & 8'hF7))
      else $error("clear bit 3 load wrong");
   direct_load_a: assert property (
      decode_cycle && operand_reg_load &&
      !(dest_register_check && compat_mode) |=>
      operand_reg_control == OPC_LOAD &&
      operand_register == instruction_byte_bus)
      else $error("direct operand load wrong");
   assemble_ctl_a: assert property (
      legacy_first_decode_flag && !decode_cycle |=>
      operand_reg_control == OPC_ASSEMBLE &&
      operand_register[3] == 1'b0)
      else $error("assemble not applied");
   assemble_shift_a: assert property (
      legacy_first_decode_flag && !decode_cycle |=>
      operand_register[7:4] == $past(operand_register[5:2]) &&
      operand_register[2] == $past(operand_register[0]) &&
      operand_register[1:0] == instruction_byte_bus[7:6])
      else $error("register number assembly wrong");
   backup_clear_a: assert property (
      first_decode_strobe |=> !backup_mask_valid)
      else $error("backup flag not cleared");
   flag_clear_a: assert property (
      !first_decode_strobe |=> !legacy_first_decode_flag)
      else $error("flag not cleared");
   native_class_c: cover property (first_decode_strobe && !compat_mode);
   compat_seq_c: cover property (
      first_decode_strobe && compat_mode ##1 !decode_cycle);
   intr_c: cover property (spec_table_en && dispatch_addr == INTR_DISPATCH);
   compat_clr3_c: cover property (
      decode_cycle && compat_mode && dest_register_check);
endmodule

// *** logic/icd_pkg.sv ***
// Package for the instruction class decode block
package icd_pkg;
   localparam int CW_W = 19;
   localparam int CW_HOLD_PC = 18;
   localparam int CW_FUNC_HI = 11;
   localparam int CW_FUNC_LO = 9;
   localparam int CW_BYTE_REQ = 8;
   localparam int CW_UPPER_SEL = 7;
   localparam int CW_OPREG_LOAD = 6;
   localparam int CW_DEST_CHECK = 5;
   localparam int CW_TABLE_SEL = 4;
   localparam logic [2:0] FUNC_NATIVE_CLASS = 3'h3;
   localparam logic [2:0] FUNC_COMPAT_CLASS = 3'h1;
   localparam logic [7:0] INTR_DISPATCH = 8'hFF;
   localparam logic [1:0] OPC_HOLD = 2'h3;
   localparam logic [1:0] OPC_LOAD_CLR3 = 2'h2;
   localparam logic [1:0] OPC_LOAD = 2'h0;
   localparam logic [1:0] OPC_ASSEMBLE = 2'h1;
   localparam logic [7:0] OPREG_RESET = 8'h00;
   localparam logic [1:0] LATCH_RESET = 2'h0;
endpackage

// *** test/icd_useq_model.sv ***
// Microsequencer model issuing decode control words
module icd_useq_model (
   // Request from bench
   input wire logic compat,
   input wire logic [1:0] op,
   input wire logic hold,
   input wire logic te_gate,
   // Control to decoder
   output logic decode_cycle,
   output logic [icd_pkg::CW_W-1:0] control_word,
   output logic table_enable
);
   import icd_pkg::*;
   always_comb begin
      control_word = '0;
      decode_cycle = op != 2'h0;
      table_enable = decode_cycle & te_gate;
      if (op == 2'h1) begin
         control_word[CW_TABLE_SEL] = 1'b1;
         if (compat) begin
            control_word[CW_FUNC_HI:CW_FUNC_LO] = FUNC_COMPAT_CLASS;
            control_word[CW_UPPER_SEL] = 1'b1;
            control_word[CW_OPREG_LOAD] = 1'b1;
         end else begin
            control_word[CW_FUNC_HI:CW_FUNC_LO] = FUNC_NATIVE_CLASS;
            control_word[CW_BYTE_REQ] = 1'b1;
            control_word[CW_HOLD_PC] = hold;
         end
      end else if (op == 2'h2) begin
         control_word[CW_OPREG_LOAD] = compat;
         control_word[CW_DEST_CHECK] = compat;
         control_word[CW_TABLE_SEL] = ~compat;
         control_word[CW_HOLD_PC] = 1'b1;
         control_word[CW_FUNC_HI:CW_FUNC_LO] = compat ? 3'h6 : 3'h2;
      end
   end
endmodule

// *** test/instruction_class_decode_test.sv ***
// Self-checking bench for the instruction class decode
module instruction_class_decode_test;
   timeunit 1ns;
   timeprecision 1ns;
   import icd_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic cm = 1'b0, hold = 1'b0, te_gate = 1'b1, intr = 1'b0;
   logic smask = 1'b0, valid = 1'b1, cbr = 1'b0, cmet = 1'b0;
   logic [1:0] op = 2'h0, pcl = 2'h0, csz = 2'h0, ccc = 2'h0;
   logic [31:0] pbuf = 32'h0, pci = 32'h0;
   logic [7:0] otd = 8'h00, std_d = 8'h00;
   logic decode_cycle, table_enable, dv, ote, ste, brm, lsw, wrw;
   logic bnt, flg, bmv;
   logic [CW_W-1:0] control_word;
   logic [7:0] da, opc, ibb, opr;
   logic [1:0] bsel, osz, cccl, ctl;
   logic [31:0] lsd;
   int num_errors = 0;
   int total_checks = 0;
   int seed = 32'h0000DC26;
   always #50 mclk = ~mclk;
   icd_class_decode icd_class_decode_i (.mclk, .rst_b, .decode_cycle,
      .control_word, .table_enable, .compat_mode(cm), .intr_pending(intr),
      .set_backup_mask(smask), .prefetch_buffer(pbuf),
      .fetched_byte_valid(valid), .pc_low(pcl), .pc_incremented(pci),
      .class_size(csz), .class_cc(ccc), .is_cond_branch(cbr),
      .cond_met(cmet), .opcode_table_data(otd), .spec_table_data(std_d),
      .dispatch_valid(dv), .dispatch_addr(da), .opcode_table_en(ote),
      .spec_table_en(ste), .opcode_reg(opc), .instruction_byte_bus(ibb),
      .byte_removed(brm), .byte_select(bsel), .ls_pc_write(lsw),
      .ls_pc_data(lsd), .wr_pc_write(wrw), .operand_size(osz),
      .cc_class_latch(cccl), .branch_not_taken(bnt),
      .legacy_first_decode_flag(flg), .operand_register(opr),
      .operand_reg_control(ctl), .backup_mask_valid(bmv));
   icd_useq_model icd_useq_model_i (.compat(cm), .op, .hold, .te_gate,
      .decode_cycle, .control_word, .table_enable);
   function automatic logic [7:0] pick(input logic [31:0] w,
                                       input logic [1:0] s);
      return w[8*s +: 8];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic class_dec(input logic m);
      logic [31:0] r;
      logic [7:0] b;
      logic [7:0] lo;
      r = $random(seed);
      cm = m;
      op = 2'h0;
      smask = 1'b1;
      pcl = m ? {r[26], 1'b0} : r[26:25];
      @(negedge mclk);
      chk(bmv, 1'b1);
      smask = 1'b0;
      pbuf = $random(seed);
      pci = $random(seed);
      otd = r[7:0];
      std_d = r[15:8];
      {csz, ccc, cbr, cmet, hold, intr, te_gate} = r[24:16];
      b = pick(pbuf, m ? {pcl[1], 1'b1} : pcl);
      op = 2'h1;
      @(negedge mclk);
      chk(ibb, b);
      chk({dv, opc, brm}, {te_gate, b, 1'b1});
      chk(lsw, !m);
      if (!m) chk({lsd, bsel}, {pci, pci[1:0]});
      chk(wrw, !m && !hold);
      chk(da, (!m && intr) ? INTR_DISPATCH : otd);
      chk({ote, ste}, {te_gate & (m | !intr), te_gate & !m & intr});
      chk({osz, cccl}, {csz, ccc});
      chk(bnt, cbr & !cmet);
      chk({flg, bmv}, 2'h2);
      chk(ctl, m ? OPC_LOAD : OPC_HOLD);
      if (m) chk(opr, b);
      op = 2'h0;
      @(negedge mclk);
      chk({flg, ctl}, {1'b0, OPC_ASSEMBLE});
      lo = pick(pbuf, pcl);
      if (m) chk(opr, {b[5:2], 1'b0, b[0], lo[7:6]});
      if (m) chk(opr & 8'hEE, {b[5:3], 2'h0, b[0], lo[7], 1'b0});
   endtask
   task automatic other_dec(input logic m);
      logic [7:0] b;
      logic [1:0] s;
      cm = m;
      op = 2'h0;
      pcl = 2'h2;
      @(negedge mclk);
      s = osz;
      b = pick(pbuf, 2'h2);
      op = 2'h2;
      @(negedge mclk);
      chk({flg, osz}, {1'b0, s});
      chk(brm, m);
      if (m) chk({ctl, opr}, {OPC_LOAD_CLR3, b & 8'hF7});
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      chk({ctl, opr}, {OPC_HOLD, OPREG_RESET});
      for (int i = 0; i < 60; i++) class_dec(i[0]);
      $display("class decode tests done");
      other_dec(1'b0);
      other_dec(1'b1);
      $display("other decode tests done");
      valid = 1'b0;
      op = 2'h1;
      @(negedge mclk);
      chk({flg, dv}, 2'h0);
      valid = 1'b1;
      op = 2'h0;
      $display("invalid byte test done");
      report_and_stop();
   end
   initial begin
      repeat (2000) @(posedge mclk);
      num_errors++;
      report_and_stop();
   end
endmodule
